// *** rtl/ecu_pkg.sv ***
// Package for the event capture unit channel: register map, fields, reset values
package ecu_pkg;

  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;  // capture_channel_control
  localparam logic [3:0] ADDR_TIME    = 4'h4;  // capture_time_register
  localparam logic [3:0] ADDR_PENDING = 4'h8;  // event_pending_register
  localparam logic [3:0] ADDR_STATUS  = 4'hC;  // channel state, read only

  // Control field positions
  localparam int CTL_OVERWRITE_BIT = 0;
  localparam int CTL_ENABLE_BIT    = 1;
  localparam int CTL_RISE_BIT      = 2;
  localparam int CTL_FALL_BIT      = 3;
  localparam int CTL_OVR_IE_BIT    = 4;
  localparam int CTL_CAP_IE_BIT    = 5;

  // Pending field positions (write one to clear)
  localparam int PEND_CAPTURE_BIT = 0;
  localparam int PEND_OVERRUN_BIT = 1;

  // Reset values
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam int         TIMER_WIDTH   = 16;

  // Bus answer latency in cycles after request is seen
  localparam int BUS_WAIT_CYCLES = 1;

  // Control register layout
  typedef struct packed {
    logic cap_ie;
    logic ovr_ie;
    logic fall;
    logic rise;
    logic enable;
    logic overwrite;
  } ecu_control_t;

  // Capture slot: a time value plus its full flag
  typedef struct packed {
    logic                   full;
    logic [TIMER_WIDTH-1:0] value;
  } ecu_slot_t;

endpackage : ecu_pkg

// *** rtl/ecu_capture_channel.sv ***
// One input-capture channel with a single-entry buffer and overrun handling
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module ecu_capture_channel #(
  parameter int TW = ecu_pkg::TIMER_WIDTH
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rstn,
  // Free-running timer value to be captured
  input  wire logic [TW-1:0] timer_value,
  // External event input pin
  input  wire logic          event_pin,
  // Avalon-MM slave
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // Interrupt requests
  output logic               capture_irq,
  output logic               overrun_irq
);

  // Pin synchroniser and edge history
  logic sync1_q, sync2_q, prev_q;
  logic sync1_d, sync2_d, prev_d;
  // Channel state
  ecu_pkg::ecu_control_t ctl_q, ctl_d;
  ecu_pkg::ecu_slot_t    buf_q, buf_d;       // Capture buffer
  ecu_pkg::ecu_slot_t    time_q, time_d;     // capture_time_register
  logic                  cap_pend_q, cap_pend_d;
  logic                  channel_overrun_flag_q, channel_overrun_flag_d;
  // Bus handshake
  logic                  ack_q, ack_d;
  logic [31:0]           rdata_q, rdata_d;

  logic edge_valid, read_time, overrun, accept, moved;

  // Two flops before the pin is looked at, then an edge detector on the second
  // History resets low: a pin already high at reset shows one rising edge
  always_comb begin
    sync1_d = event_pin;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  assign edge_valid = ctl_q.enable &
                      ((ctl_q.rise & sync2_q & ~prev_q) | (ctl_q.fall & ~sync2_q & prev_q));
  // Request is completed on the cycle the waitrequest drops
  assign read_time  = avs_read & ack_q & (avs_address == ecu_pkg::ADDR_TIME);
  // A read in the same cycle frees a slot, so that edge is no overrun
  assign overrun    = edge_valid & buf_q.full & time_q.full & ~read_time;
  assign accept     = edge_valid & ~(overrun & ~ctl_q.overwrite);

  // Capture path, buffer, time register and pending flags
  always_comb begin
    // Hold everything unless an event below moves it
    ctl_d                  = ctl_q;
    buf_d                  = buf_q;
    time_d                 = time_q;
    cap_pend_d             = cap_pend_q;
    channel_overrun_flag_d = channel_overrun_flag_q;
    moved                  = 1'b0;
    // Read empties the register; buffered time moves in
    if (read_time) begin
      time_d.full = 1'b0;
      if (buf_q.full) begin
        time_d = buf_q;
        buf_d.full = 1'b0;
        moved = 1'b1;
      end
    end
    // New edge lands in the free slot, or overwrites the buffer
    if (accept) begin
      if (!time_d.full && !buf_d.full) begin
        time_d = '{full: 1'b1, value: timer_value};
        moved = 1'b1;                        // Straight transfer into the register
      end else begin
        buf_d = '{full: 1'b1, value: timer_value};
      end
    end
    // Set wins over a clear in the same cycle
    if (avs_write && ack_q && avs_address == ecu_pkg::ADDR_PENDING) begin
      if (avs_writedata[ecu_pkg::PEND_CAPTURE_BIT]) cap_pend_d = 1'b0;
      if (avs_writedata[ecu_pkg::PEND_OVERRUN_BIT]) channel_overrun_flag_d = 1'b0;
    end
    if (read_time) cap_pend_d = 1'b0;
    if (moved) cap_pend_d = 1'b1;
    // Register never left unread without a pending bit, even on read-edge collision
    if (time_d.full && read_time && accept) cap_pend_d = 1'b1;
    // Kept overrun flags the channel; the edge itself is dropped by accept
    if (overrun && !ctl_q.overwrite) channel_overrun_flag_d = 1'b1;
    if (avs_write && ack_q && avs_address == ecu_pkg::ADDR_CONTROL) begin
      ctl_d = avs_writedata[5:0];
    end
  end

  // One wait state: first cycle holds waitrequest, second completes
  always_comb begin
    ack_d   = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    // Captured in the first cycle so it stands when waitrequest drops
    if (avs_read && !ack_q) begin
      unique case (avs_address)
        ecu_pkg::ADDR_CONTROL: rdata_d = {26'h0, ctl_q};
        ecu_pkg::ADDR_TIME:    rdata_d = {{(32-TW){1'b0}}, time_q.value};
        ecu_pkg::ADDR_PENDING: rdata_d = {30'h0, channel_overrun_flag_q, cap_pend_q};
        ecu_pkg::ADDR_STATUS:  rdata_d = {30'h0, buf_q.full, time_q.full};
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_q                <= 1'b0;
      sync2_q                <= 1'b0;
      prev_q                 <= 1'b0;
      ctl_q                  <= ecu_pkg::CONTROL_RESET;
      buf_q                  <= '0;
      time_q                 <= '0;
      cap_pend_q             <= 1'b0;
      channel_overrun_flag_q <= 1'b0;
      ack_q                  <= 1'b0;
      rdata_q                <= 32'h0000_0000;
    end else begin
      sync1_q                <= sync1_d;
      sync2_q                <= sync2_d;
      prev_q                 <= prev_d;
      ctl_q                  <= ctl_d;
      buf_q                  <= buf_d;
      time_q                 <= time_d;
      cap_pend_q             <= cap_pend_d;
      channel_overrun_flag_q <= channel_overrun_flag_d;
      ack_q                  <= ack_d;
      rdata_q                <= rdata_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign capture_irq     = cap_pend_q & ctl_q.cap_ie;
  assign overrun_irq     = channel_overrun_flag_q & ctl_q.ovr_ie;

  // Named steps shared by the checks below
  sequence s_overrun_keep;
    overrun && !ctl_q.overwrite;
  endsequence
  sequence s_overrun_replace;
    overrun && ctl_q.overwrite;
  endsequence
  sequence s_read_buffered;
    read_time && buf_q.full;
  endsequence
  sequence s_read_edge_collide;
    read_time && edge_valid;
  endsequence

  // Overrun with both slots full and overwrite on replaces the buffer
  a_overwrite_replace: assert property (@(posedge clock) disable iff (!rstn)
    s_overrun_replace |=> buf_q.full && buf_q.value == $past(timer_value))
    else $error("buffer not replaced on overrun");
  // Ignored edge leaves both slots unchanged
  a_ignore_edge: assert property (@(posedge clock) disable iff (!rstn)
    s_overrun_keep |=> $stable(buf_q) && $stable(time_q))
    else $error("edge not ignored while full");
  // Both full with overwrite off: nothing moves until software reads
  a_full_hold: assert property (@(posedge clock) disable iff (!rstn)
    !ctl_q.overwrite && buf_q.full && time_q.full && !read_time
    |=> $stable(buf_q) && $stable(time_q))
    else $error("slots changed while full and not read");

  // Kept overrun raises the channel flag
  a_overrun_flag: assert property (@(posedge clock) disable iff (!rstn)
    s_overrun_keep |=> channel_overrun_flag_q)
    else $error("overrun flag not set");
  // Flag only ever rises after an edge met two full slots
  a_overrun_detect: assert property (@(posedge clock) disable iff (!rstn)
    $rose(channel_overrun_flag_q) |-> $past(edge_valid && buf_q.full && time_q.full))
    else $error("overrun flag without a full-slot edge");

  // Read with data buffered pulls it into the time register
  a_read_moves: assert property (@(posedge clock) disable iff (!rstn)
    s_read_buffered |=> time_q.full && time_q.value == $past(buf_q.value))
    else $error("buffer not moved on read");
  // Without a fresh edge the read leaves the buffer empty
  a_read_empties: assert property (@(posedge clock) disable iff (!rstn)
    read_time && buf_q.full && !edge_valid |=> !buf_q.full)
    else $error("buffer not emptied on read");
  // Capture pending rises only on a transfer into the register
  a_pend_on_move: assert property (@(posedge clock) disable iff (!rstn)
    $rose(cap_pend_q) |-> $past(moved))
    else $error("capture pending set without transfer");
  // Every transfer leaves capture pending set, even against a clear
  a_move_sets_pend: assert property (@(posedge clock) disable iff (!rstn)
    moved |=> cap_pend_q)
    else $error("transfer without capture pending");
  // Kept overrun with its interrupt enabled raises the request
  a_ovr_irq: assert property (@(posedge clock) disable iff (!rstn)
    s_overrun_keep ##0 ctl_q.ovr_ie ##1 ctl_q.ovr_ie |-> overrun_irq)
    else $error("overrun irq missing");

  // Time register filled by a read never sits without a pending bit
  a_no_stuck: assert property (@(posedge clock) disable iff (!rstn)
    time_q.full && $past(read_time) |-> cap_pend_q)
    else $error("unread time without pending");
  // Read at the instant an edge validates still ends with data and pending
  a_collide_pend: assert property (@(posedge clock) disable iff (!rstn)
    s_read_edge_collide |=> time_q.full && cap_pend_q)
    else $error("read-edge collision left no pending");

endmodule // ecu_capture_channel

// *** verification/ecu_event_src.sv ***
// Partner model: external event source feeding the capture pin
`timescale 1ns/100ps
module ecu_event_src (
  // Clock and request
  input  wire logic clock,
  input  wire logic fire,
  // Event pin
  output logic      event_pin
);
  logic [2:0] cnt_q = 3'h0;
  logic [2:0] cnt_d;

  // High pulse of four cycles, long enough to pass the two-flop synchroniser
  always_comb cnt_d = fire ? 3'h4 : ((cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0);
  always_ff @(posedge clock) cnt_q <= cnt_d;
  assign event_pin = (cnt_q != 3'h0);
endmodule // ecu_event_src

// *** verification/capture_channel_overrun_buffer_test.sv ***
// Self-checking testbench for the capture channel with overrun buffer
`timescale 1ns/100ps
module capture_channel_overrun_buffer_test;
  logic        clock = 1'b0, rstn = 1'b0, fire = 1'b0, event_pin;
  logic [15:0] timer_value = 16'h0000;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        capture_irq, overrun_irq;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #20 clock = ~clock;

  ecu_event_src ecu_event_src_i (.clock(clock), .fire(fire), .event_pin(event_pin));
  ecu_capture_channel ecu_capture_channel_i (.clock(clock), .rstn(rstn),
    .timer_value(timer_value), .event_pin(event_pin), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_irq(capture_irq), .overrun_irq(overrun_irq));

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Avalon cycle held until waitrequest is seen low; a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    check("bus wait", 32'(ecu_pkg::BUS_WAIT_CYCLES + 1), 32'(n));
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // One pin pulse, a rising then a falling edge, with the timer parked at a known value
  task automatic pulse(input logic [15:0] t);
    @(posedge clock);
    timer_value <= t;
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (12) @(posedge clock);
  endtask

  task automatic t_reset;
    bus(1'b0, ecu_pkg::ADDR_CONTROL, 32'h0);
    check("control", 32'h0, rd);
    bus(1'b0, ecu_pkg::ADDR_PENDING, 32'h0);
    check("pending", 32'h0, rd);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0, rd);
    check("irqs", 32'h0, {30'h0, capture_irq, overrun_irq});
    // Channel still disabled: an edge must not be captured
    pulse(16'h0F0F);
    bus(1'b0, ecu_pkg::ADDR_STATUS, 32'h0);
    check("disabled", 32'h0, rd);
    $display("reset test done");
  endtask

  task automatic t_capture;
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h26);
    pulse(16'h1111);
    check("capture irq", 32'h1, {31'h0, capture_irq});
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("time", 32'h1111, rd);
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    $display("capture test done");
  endtask

  task automatic t_keep_old;
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h16);
    pulse(16'hA001);
    pulse(16'hA002);
    pulse(16'hA003);
    bus(1'b0, ecu_pkg::ADDR_STATUS, 32'h0);
    check("status", 32'h3, rd);
    bus(1'b0, ecu_pkg::ADDR_PENDING, 32'h0);
    check("overrun", 32'h2, rd & 32'h2);
    check("overrun irq", 32'h1, {31'h0, overrun_irq});
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("time 1", 32'hA001, rd);
    bus(1'b0, ecu_pkg::ADDR_PENDING, 32'h0);
    check("refill", 32'h1, rd & 32'h1);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("time 2", 32'hA002, rd);
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    $display("overrun keep test done");
  endtask

  task automatic t_overwrite;
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h07);
    pulse(16'hB001);
    pulse(16'hB002);
    pulse(16'hB003);
    bus(1'b0, ecu_pkg::ADDR_PENDING, 32'h0);
    check("no overrun", 32'h0, rd & 32'h2);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("time 1", 32'hB001, rd);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("time 3", 32'hB003, rd);
    $display("overwrite test done");
  endtask

  // Read completes on the very cycle an edge validates, overwrite on, pending clear
  task automatic t_collide;
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h27);
    pulse(16'hC001);
    pulse(16'hC002);
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    fork
      pulse(16'hC003);
      begin
        repeat (2) @(posedge clock);
        bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
      end
    join
    check("collide time", 32'hC001, rd);
    bus(1'b0, ecu_pkg::ADDR_PENDING, 32'h0);
    check("collide pend", 32'h1, rd & 32'h1);
    check("collide irq", 32'h1, {31'h0, capture_irq});
    bus(1'b0, ecu_pkg::ADDR_STATUS, 32'h0);
    check("collide status", 32'h3, rd);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("collide next", 32'hC002, rd);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("collide last", 32'hC003, rd);
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    $display("collision test done");
  endtask

  // Falling edge only, then both edges of one pulse
  task automatic t_fall;
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h2A);
    pulse(16'hD001);
    bus(1'b0, ecu_pkg::ADDR_STATUS, 32'h0);
    check("fall status", 32'h1, rd);
    check("fall irq", 32'h1, {31'h0, capture_irq});
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("fall time", 32'hD001, rd);
    bus(1'b1, ecu_pkg::ADDR_CONTROL, 32'h2E);
    pulse(16'hD002);
    bus(1'b0, ecu_pkg::ADDR_STATUS, 32'h0);
    check("both status", 32'h3, rd);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("both time 1", 32'hD002, rd);
    bus(1'b0, ecu_pkg::ADDR_TIME, 32'h0);
    check("both time 2", 32'hD002, rd);
    bus(1'b1, ecu_pkg::ADDR_PENDING, 32'h3);
    $display("edge select test done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this limit is far above it
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_capture();
    t_keep_old();
    t_overwrite();
    t_collide();
    t_fall();
    close_out();
  end
endmodule // capture_channel_overrun_buffer_test
